// ==== hdl/rsr_entry_word.sv ====
// Forms one dword of a registered-controller entry in either layout.
// Assumes wordIdx counts dwords from the start of the entry.
`timescale 1ns/1ps
`default_nettype none
module rsr_entry_word (
    input  wire logic         extLayout,
    input  wire logic [3:0]   wordIdx,
    input  wire logic [15:0]  ctlId,
    input  wire logic         held,
    input  wire logic         unbound,
    input  wire logic [127:0] host_identifier,
    input  wire logic [63:0]  resvKey,
    output logic      [31:0]  word
);
    import rsr_pkg::*;

    logic [31:0] firstWord;

    // Byte 2 bit 0 is the flag; bits 7:1 and byte 3 stay zero
    assign firstWord = {8'h00, 7'h00, held,
                        (unbound ? UNBOUND_CTL_ID : ctlId)}; // RULE6 RULE7 RULE8

    always_comb begin
        word = 32'h0000_0000; // RULE17
        if (extLayout) begin
            case (wordIdx)
                4'h0:    word = firstWord;        // RULE11
                4'h2:    word = resvKey[31:0];    // RULE11
                4'h3:    word = resvKey[63:32];
                4'h4:    word = host_identifier[31:0];     // RULE12
                4'h5:    word = host_identifier[63:32];
                4'h6:    word = host_identifier[95:64];
                4'h7:    word = host_identifier[127:96];
                default: word = 32'h0000_0000;    // RULE12
            endcase
        end else begin
            case (wordIdx)
                4'h0:    word = firstWord;
                4'h2:    word = host_identifier[31:0];     // RULE9
                4'h3:    word = host_identifier[63:32];
                4'h4:    word = resvKey[31:0];    // RULE10
                4'h5:    word = resvKey[63:32];
                default: word = 32'h0000_0000;    // RULE9
            endcase
        end
    end

endmodule : rsr_entry_word
`default_nettype wire

// ==== hdl/rsr_formatter.sv ====
// Reservation status report formatter: AHB-Lite register slave holding the
// header fields and a controller table, and a dword stream of the report.
// Assumes one clock, synchronous reset, and a sink that may stall the stream.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - persistence state goes in header byte 9
// RULE2 - state: release-on-power-on or retain
// RULE3 - basic entries of 24 bytes from byte 24
// RULE4 - extended header bytes 23:0 same as basic
// RULE5 - extended bytes 63:24 zero, 64-byte entries
// RULE6 - entry bytes 1:0 hold controller identifier
// RULE7 - unbound dynamic controller reports all ones
// RULE8 - byte 2 bit 0 is reservation held
// RULE9 - basic: 7:3 reserved, 64-bit host id
// RULE10 - basic: reservation key in bytes 23:16
// RULE11 - extended: key moves to bytes 15:8
// RULE12 - extended: 128-bit host id, 63:32 reserved
// RULE13 - one request bit selects extended layout
// RULE14 - send exactly requested dwords, not past report
// RULE15 - header bytes 3:0 wrapping generation counter
// RULE16 - header bytes 6:5 hold entry count
// RULE17 - reserved bytes and bits are zero
// RULE18 - state encoded 0 release, 1 retain
module rsr_formatter #(
    parameter int MAX_ENTRIES = 4
) (
    input  wire logic                       clk_sys,
    input  wire logic                       srst,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [rsr_pkg::WORD_W-1:0] hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic      [rsr_pkg::WORD_W-1:0] hrdata,
    input  wire logic                       genEvent,
    output logic                            rptValid,
    input  wire logic                       rptReady,
    output logic      [rsr_pkg::WORD_W-1:0] rptData,
    output logic                            rptLast,
    output logic                            busy
);
    import rsr_pkg::*;

    localparam int IW = (MAX_ENTRIES > 1) ? $clog2(MAX_ENTRIES) : 1;

    // ********************************************************
    // Declarations
    // ********************************************************
    rsr_state_t   state;
    logic         dpWrite;
    logic [7:0]   dpAddr;
    logic         wrEn;
    logic         startReq;
    logic [31:0]  dwCount;
    logic         extSel;
    logic         persistState;
    logic [7:0]   resvType;
    logic [15:0]  entryCount;
    logic [31:0]  genCount;
    logic [IW-1:0] selIdx;
    logic [15:0]  tblId   [MAX_ENTRIES];
    logic         tblHeld [MAX_ENTRIES];
    logic         tblDyn  [MAX_ENTRIES];
    logic [127:0] tblHost [MAX_ENTRIES];
    logic [63:0]  tblKey  [MAX_ENTRIES];
    logic         snapExt;
    logic         snapPersist;
    logic [7:0]   snapType;
    logic [15:0]  snapCount;
    logic [31:0]  snapGen;
    logic [32:0]  remaining;
    logic [32:0]  totalDw;
    logic [31:0]  sentCount;
    logic         inHdr;
    logic [3:0]   wordIdx;
    logic [15:0]  entryIdx;
    logic [31:0]  dwIdx;
    logic [31:0]  outIdx;
    logic         outHdr;
    logic [3:0]   outWord;
    logic [15:0]  outEntry;
    logic [32:0]  reqLen;
    logic [32:0]  rptLen;
    logic [32:0]  next_total;
    logic [15:0]  wrCount;
    logic         loadOut;
    logic [31:0]  hdrWord;
    logic [31:0]  entWord;
    logic [IW-1:0] curEnt;
    logic [3:0]   hdrLast;
    logic [3:0]   entLast;

    // ********************************************************
    // AHB-Lite slave: zero wait states, always OKAY
    // ********************************************************
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Register readback; unmapped offsets read zero
    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            OFF_CTRL:   r = {30'h0, extSel, (state != ST_IDLE)};
            OFF_DWCNT:  r = dwCount;
            OFF_HDRCFG: r = {entryCount, resvType, 7'h00, persistState};
            OFF_GEN:    r = genCount;
            OFF_SEL:    r = 32'(selIdx);
            OFF_ENTCTL: r = {14'h0, tblDyn[selIdx], tblHeld[selIdx], tblId[selIdx]};
            OFF_HOST0:  r = tblHost[selIdx][31:0];
            OFF_HOST1:  r = tblHost[selIdx][63:32];
            OFF_HOST2:  r = tblHost[selIdx][95:64];
            OFF_HOST3:  r = tblHost[selIdx][127:96];
            OFF_KEY0:   r = tblKey[selIdx][31:0];
            OFF_KEY1:   r = tblKey[selIdx][63:32];
            OFF_SENT:   r = sentCount;
            default:    r = 32'h0000_0000;
        endcase
        return r;
    endfunction : regRead

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dpWrite <= 1'b0;
            dpAddr  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            dpWrite <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                dpAddr <= haddr[7:0];
            end
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= regRead(haddr[7:0]);
            end
        end
    end

    assign wrEn     = dpWrite;
    assign startReq = wrEn && (dpAddr == OFF_CTRL) && hwdata[CTRL_START_BIT]
                      && (state == ST_IDLE);
    assign wrCount  = (hwdata[31:HDRCFG_COUNT_LSB] > 16'(MAX_ENTRIES)) ?
                      16'(MAX_ENTRIES) : hwdata[31:HDRCFG_COUNT_LSB];

    // ********************************************************
    // Configuration registers
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dwCount      <= DWCNT_RESET;
            extSel       <= 1'b0;
            persistState <= PERSIST_RELEASE;
            resvType     <= 8'h00;
            entryCount   <= 16'h0000;
            selIdx       <= '0;
        end else if (wrEn) begin
            case (dpAddr)
                OFF_CTRL:   extSel <= hwdata[CTRL_EXT_BIT]; // RULE13
                OFF_DWCNT:  dwCount <= hwdata;
                OFF_HDRCFG: begin
                    persistState <= hwdata[HDRCFG_PERSIST_BIT]; // RULE2 RULE18
                    resvType     <= hwdata[HDRCFG_RTYPE_LSB +: 8];
                    entryCount   <= wrCount; // RULE16
                end
                OFF_SEL:    selIdx <= hwdata[IW-1:0];
                default:    selIdx <= selIdx;
            endcase
        end
    end

    // Wrapping count of reservation-changing completions
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            genCount <= GEN_RESET;
        end else if (genEvent) begin
            genCount <= genCount + 32'h0000_0001; // RULE15
        end
    end

    // ********************************************************
    // Controller table; frozen while a report streams out
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < MAX_ENTRIES; i++) begin
                tblId[i]   <= 16'h0000;
                tblHeld[i] <= 1'b0;
                tblDyn[i]  <= 1'b0;
                tblHost[i] <= 128'h0;
                tblKey[i]  <= 64'h0;
            end
        end else if (wrEn && (state == ST_IDLE)) begin
            case (dpAddr)
                OFF_ENTCTL: begin
                    tblId[selIdx]   <= hwdata[15:0];
                    tblHeld[selIdx] <= hwdata[ENT_HELD_BIT];
                    tblDyn[selIdx]  <= hwdata[ENT_DYN_BIT];
                end
                OFF_HOST0: tblHost[selIdx][31:0]   <= hwdata;
                OFF_HOST1: tblHost[selIdx][63:32]  <= hwdata;
                OFF_HOST2: tblHost[selIdx][95:64]  <= hwdata;
                OFF_HOST3: tblHost[selIdx][127:96] <= hwdata;
                OFF_KEY0:  tblKey[selIdx][31:0]    <= hwdata;
                OFF_KEY1:  tblKey[selIdx][63:32]   <= hwdata;
                default:   tblKey[selIdx]          <= tblKey[selIdx];
            endcase
        end
    end

    // ********************************************************
    // Report length and sequencing
    // ********************************************************
    // Layout comes from the start write itself so one write both picks and starts
    assign reqLen = {1'b0, dwCount} + 33'd1; // RULE14
    assign rptLen = hwdata[CTRL_EXT_BIT] ?
        33'(HDR_DW_EXT) + 33'(ENT_DW_EXT) * {17'h0, entryCount} :    // RULE5
        33'(HDR_DW_BASIC) + 33'(ENT_DW_BASIC) * {17'h0, entryCount}; // RULE3
    assign next_total = (reqLen < rptLen) ? reqLen : rptLen; // RULE14

    assign hdrLast = snapExt ? 4'(HDR_DW_EXT - 1) : 4'(HDR_DW_BASIC - 1); // RULE4
    assign entLast = snapExt ? 4'(ENT_DW_EXT - 1) : 4'(ENT_DW_BASIC - 1);
    assign loadOut = (state == ST_SEND) && (!rptValid || rptReady) && (remaining != 33'd0);
    assign curEnt  = entryIdx[IW-1:0];
    assign busy    = (state != ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state       <= ST_IDLE;
            snapExt     <= 1'b0;
            snapPersist <= PERSIST_RELEASE;
            snapType    <= 8'h00;
            snapCount   <= 16'h0000;
            snapGen     <= GEN_RESET;
            remaining   <= 33'd0;
            totalDw     <= 33'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (startReq) begin
                        state       <= ST_SEND;
                        snapExt     <= hwdata[CTRL_EXT_BIT]; // RULE13
                        snapPersist <= persistState;
                        snapType    <= resvType;
                        snapCount   <= entryCount;
                        snapGen     <= genCount;
                        remaining   <= next_total;
                        totalDw     <= next_total;
                    end
                end
                ST_SEND: begin
                    if (loadOut) begin
                        remaining <= remaining - 33'd1; // RULE14
                    end
                    if ((remaining == 33'd0) && (!rptValid || rptReady)) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Position walker: header dwords first, then entry after entry
    always_ff @(posedge clk_sys) begin
        if (srst || startReq) begin
            inHdr    <= 1'b1;
            wordIdx  <= 4'h0;
            entryIdx <= 16'h0000;
            dwIdx    <= 32'h0000_0000;
        end else if (loadOut) begin
            dwIdx <= dwIdx + 32'h0000_0001;
            if (inHdr ? (wordIdx == hdrLast) : (wordIdx == entLast)) begin
                wordIdx <= 4'h0;
                inHdr   <= 1'b0; // RULE3 RULE5
                if (!inHdr) begin
                    entryIdx <= entryIdx + 16'h0001;
                end
            end else begin
                wordIdx <= wordIdx + 4'h1;
            end
        end
    end

    // ********************************************************
    // Dword formation and output register
    // ********************************************************
    rsr_hdr_word u_hdr (
        .hdrIdx       (wordIdx),
        .genCount     (snapGen),
        .entryCount   (snapCount),
        .resvType     (snapType),
        .persistState (snapPersist),
        .word         (hdrWord)
    );

    rsr_entry_word u_ent (
        .extLayout (snapExt),
        .wordIdx   (wordIdx),
        .ctlId     (tblId[curEnt]),
        .held      (tblHeld[curEnt]),
        .unbound   (tblDyn[curEnt]),
        .host_identifier    (tblHost[curEnt]),
        .resvKey   (tblKey[curEnt]),
        .word      (entWord)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rptValid  <= 1'b0;
            rptData   <= 32'h0000_0000;
            rptLast   <= 1'b0;
            outIdx    <= 32'h0000_0000;
            outHdr    <= 1'b0;
            outWord   <= 4'h0;
            outEntry  <= 16'h0000;
        end else if (loadOut) begin
            rptValid <= 1'b1;
            rptData  <= inHdr ? hdrWord : entWord;
            rptLast  <= (remaining == 33'd1); // RULE14
            outIdx   <= dwIdx;
            outHdr   <= inHdr;
            outWord  <= wordIdx;
            outEntry <= entryIdx;
        end else if (rptReady) begin
            rptValid <= 1'b0;
            rptLast  <= 1'b0;
        end
    end

    // Accepted dwords, readable by software after the report
    always_ff @(posedge clk_sys) begin
        if (srst || startReq) begin
            sentCount <= 32'h0000_0000;
        end else if (rptValid && rptReady) begin
            sentCount <= sentCount + 32'h0000_0001;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    chk_persist_byte: assert property ( // RULE1
        rptValid && outHdr && outIdx == 32'd2 |-> rptData[15:8] == {7'h00, snapPersist})
        else $error("persistence state not in header byte 9");
    chk_basic_entry_base: assert property ( // RULE3
        rptValid && !snapExt && outIdx == 32'd6 |-> !outHdr && outEntry == 16'd0 && outWord == 4'd0)
        else $error("basic entry 0 does not start at byte 24");
    chk_ext_hdr_span: assert property ( // RULE4
        rptValid && snapExt && outIdx < 32'd6 |-> outHdr && outWord == outIdx[3:0])
        else $error("extended header bytes 23:0 misplaced");
    chk_ext_reserved: assert property ( // RULE5
        rptValid && snapExt && outIdx >= 32'd6 && outIdx < 32'd16 |-> rptData == 32'h0)
        else $error("extended reserved header bytes not zero");
    chk_unbound_id: assert property ( // RULE7
        rptValid && !outHdr && outWord == 4'd0 && tblDyn[outEntry[IW-1:0]]
        |-> rptData[15:0] == UNBOUND_CTL_ID)
        else $error("unbound controller identifier not all ones");
    chk_flag_reserved: assert property ( // RULE8
        rptValid && !outHdr && outWord == 4'd0
        |-> rptData[31:17] == 15'h0 && rptData[16] == tblHeld[outEntry[IW-1:0]])
        else $error("reservation flag byte wrong");
    chk_basic_gap: assert property ( // RULE9
        rptValid && !outHdr && !snapExt && outWord == 4'd1 |-> rptData == 32'h0)
        else $error("basic entry bytes 7:3 not zero");
    chk_exact_count: assert property ( // RULE14
        rptValid && rptReady && rptLast |=> sentCount == totalDw[31:0] && !rptValid)
        else $error("dword count of report transfer wrong");
    chk_gen_step: assert property ( // RULE15
        genEvent |=> genCount == $past(genCount) + 32'h1)
        else $error("generation counter did not step");
    chk_count_field: assert property ( // RULE16
        rptValid && outHdr && outIdx == 32'd1 |-> rptData[23:8] == snapCount)
        else $error("entry count field wrong");

endmodule : rsr_formatter
`default_nettype wire

// ==== hdl/rsr_hdr_word.sv ====
// Forms one dword of the report header from the snapshotted header fields.
// Assumes hdrIdx counts dwords from byte 0; dwords past the header read zero.
`timescale 1ns/1ps
`default_nettype none
module rsr_hdr_word (
    input  wire logic [3:0]  hdrIdx,
    input  wire logic [31:0] genCount,
    input  wire logic [15:0] entryCount,
    input  wire logic [7:0]  resvType,
    input  wire logic        persistState,
    output logic      [31:0] word
);
    import rsr_pkg::*;

    always_comb begin
        case (hdrIdx)
            4'h0:    word = genCount;                               // RULE15
            4'h1:    word = {8'h00, entryCount, resvType};          // RULE16
            4'h2:    word = {16'h0000, 7'h00, persistState, 8'h00}; // RULE1
            default: word = 32'h0000_0000;                          // RULE5
        endcase
    end

endmodule : rsr_hdr_word
`default_nettype wire

// ==== hdl/rsr_pkg.sv ====
// Constants and types shared by the reservation status report formatter.
// Assumes a 32-bit AHB-Lite register bus and a dword-wide report stream.
package rsr_pkg;

    localparam int WORD_W = 32;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DWCNT  = 8'h04;
    localparam logic [7:0] OFF_HDRCFG = 8'h08;
    localparam logic [7:0] OFF_GEN    = 8'h0c;
    localparam logic [7:0] OFF_SEL    = 8'h10;
    localparam logic [7:0] OFF_ENTCTL = 8'h14;
    localparam logic [7:0] OFF_HOST0  = 8'h18;
    localparam logic [7:0] OFF_HOST1  = 8'h1c;
    localparam logic [7:0] OFF_HOST2  = 8'h20;
    localparam logic [7:0] OFF_HOST3  = 8'h24;
    localparam logic [7:0] OFF_KEY0   = 8'h28;
    localparam logic [7:0] OFF_KEY1   = 8'h2c;
    localparam logic [7:0] OFF_SENT   = 8'h30;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int CTRL_START_BIT      = 0;
    localparam int CTRL_EXT_BIT        = 1;
    localparam int HDRCFG_PERSIST_BIT  = 0;
    localparam int HDRCFG_RTYPE_LSB    = 8;
    localparam int HDRCFG_COUNT_LSB    = 16;
    localparam int ENT_HELD_BIT        = 16;
    localparam int ENT_DYN_BIT         = 17;
    localparam logic [31:0] GEN_RESET  = 32'h0000_0000;
    localparam logic [31:0] DWCNT_RESET = 32'h0000_0000;
    localparam logic PERSIST_RELEASE   = 1'b0;
    localparam logic PERSIST_RETAIN    = 1'b1;
    localparam logic [15:0] UNBOUND_CTL_ID = 16'hffff;

    // ********************************************************
    // Report geometry in dwords
    // ********************************************************
    localparam int HDR_DW_BASIC = 6;
    localparam int HDR_DW_EXT   = 16;
    localparam int ENT_DW_BASIC = 6;
    localparam int ENT_DW_EXT   = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } rsr_state_t;

endpackage : rsr_pkg

// ==== tb/rsr_formatter_tb_top.sv ====
// Testbench: programs the formatter over AHB-Lite and checks report images.
// Assumes rsr_pkg, the formatter and the rsr_host_sink buffer model.
`timescale 1ns/1ps
`default_nettype none
module rsr_formatter_tb_top;
    import rsr_pkg::*;
    logic         clk_sys = 1'b0;
    logic         srst = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic         genEvent = 1'b0;
    logic         stallMode = 1'b0;
    logic         hreadyout, hresp, rptValid, rptReady, rptLast, busy;
    logic [31:0]  hrdata, rptData, rdVal;
    logic [31:0]  genExp = 32'h0;
    logic [7:0]   rtype = 8'h03;
    logic         pers = PERSIST_RETAIN;
    logic [15:0]  ids [2] = '{16'h0a5c, 16'h0003};
    logic         held [2] = '{1'b1, 1'b0};
    logic         unb [2] = '{1'b0, 1'b1};
    logic [127:0] hosts [2] = '{128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0,
                                128'h13579bdf_2468ace0_fdb97531_0eca8642};
    logic [63:0]  keys [2] = '{64'hdeadbeef_01234567, 64'h89abcdef_cafef00d};
    int           nMismatch = 0;
    int           numChecks = 0;
    int           cycles = 0;

    rsr_formatter #(.MAX_ENTRIES(4)) i_dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .genEvent(genEvent), .rptValid(rptValid), .rptReady(rptReady), .rptData(rptData),
        .rptLast(rptLast), .busy(busy));
    rsr_host_sink i_sink (.clk_sys(clk_sys), .srst(srst), .stallMode(stallMode),
        .rptValid(rptValid), .rptData(rptData), .rptLast(rptLast), .rptReady(rptReady));

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single AHB transfer; waits on hready in both phases, read data kept in rdVal
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rdVal = hrdata;
    endtask : xfer

    task automatic set_entry(input int e);
        xfer(1'b1, OFF_SEL, 32'(e));
        xfer(1'b1, OFF_ENTCTL, {14'h0, unb[e], held[e], ids[e]});
        for (int i = 0; i < 4; i++) xfer(1'b1, OFF_HOST0 + 8'(4 * i), hosts[e][32 * i +: 32]);
        xfer(1'b1, OFF_KEY0, keys[e][31:0]);
        xfer(1'b1, OFF_KEY1, keys[e][63:32]);
    endtask : set_entry

    // Entries are as long as the header in both layouts, so k / h - 1 is the entry
    function automatic logic [31:0] expw(input logic ext, input int k);
        int h;
        int e;
        int w;
        logic [31:0] r;
        h = ext ? 16 : 6;
        e = k / h - 1;
        w = k % h;
        r = 32'h0;
        if (e < 0) begin
            if (k == 0) r = genExp;
            if (k == 1) r = {8'h00, 16'h0002, rtype};
            if (k == 2) r = {16'h0, 7'h0, pers, 8'h00};
        end else if (w == 0) begin
            r = {15'h0, held[e], unb[e] ? 16'hffff : ids[e]};
        end else if (!ext && w >= 2) begin
            r = w < 4 ? hosts[e][32 * (w - 2) +: 32] : keys[e][32 * (w - 4) +: 32];
        end else if (ext && w >= 2 && w < 8) begin
            r = w < 4 ? keys[e][32 * (w - 2) +: 32] : hosts[e][32 * (w - 4) +: 32];
        end
        return r;
    endfunction : expw

    task automatic run_report(input logic ext, input logic [31:0] dw, input logic stall);
        int base;
        int n;
        base = i_sink.cnt;
        n = ext ? 48 : 18;
        if (dw + 1 < n) n = dw + 1;
        stallMode <= stall;
        xfer(1'b1, OFF_DWCNT, dw);
        xfer(1'b1, OFF_CTRL, {30'h0, ext, 1'b1});
        repeat (2) @(posedge clk_sys);
        // A report that never ends is caught by the cycle ceiling
        while (busy === 1'b1) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        chk(32'(i_sink.cnt - base), 32'(n));
        chk(32'(i_sink.lastAt), 32'(base + n - 1));
        for (int k = 0; k < n; k++) chk(i_sink.mem[base + k], expw(ext, k));
        xfer(1'b0, OFF_SENT, 32'h0);
        chk(rdVal, 32'(n));
        xfer(1'b0, OFF_CTRL, 32'h0);
        chk(rdVal, {30'h0, ext, 1'b0});
    endtask : run_report

    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        xfer(1'b0, OFF_GEN, 32'h0);
        chk(rdVal, GEN_RESET);
        xfer(1'b0, 8'h40, 32'h0);
        chk(rdVal, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        for (int e = 0; e < 2; e++) set_entry(e);
        xfer(1'b1, OFF_HDRCFG, {16'h0002, rtype, 7'h0, pers});
        repeat (3) begin
            genEvent <= 1'b1;
            @(posedge clk_sys);
            genEvent <= 1'b0;
            @(posedge clk_sys);
        end
        genExp = 32'h3;
        xfer(1'b0, OFF_GEN, 32'h0);
        chk(rdVal, genExp);
        run_report(1'b0, 32'hff, 1'b0);
        run_report(1'b1, 32'hff, 1'b1);
        pers = PERSIST_RELEASE;
        xfer(1'b1, OFF_HDRCFG, {16'h0002, rtype, 7'h0, pers});
        run_report(1'b0, 32'h4, 1'b0);
        run_report(1'b1, 32'h0, 1'b1);
        complete_run();
    end
endmodule : rsr_formatter_tb_top
`default_nettype wire

// ==== tb/rsr_host_sink.sv ====
// Host buffer model: stores accepted report dwords, may stall every other cycle.
// Assumes the formatter's report stream on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module rsr_host_sink (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        stallMode,
    input  wire logic        rptValid,
    input  wire logic [31:0] rptData,
    input  wire logic        rptLast,
    output logic             rptReady
);
    logic [31:0] mem [0:255];
    int          cnt;
    int          lastAt;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rptReady <= 1'b0;
            cnt      <= 0;
            lastAt   <= -1;
        end else begin
            // Stalling makes each dword wait through one held cycle
            rptReady <= stallMode ? ~rptReady : 1'b1;
            if (rptValid && rptReady) begin
                mem[cnt] <= rptData;
                cnt      <= cnt + 1;
                if (rptLast) begin
                    lastAt <= cnt;
                end
            end
        end
    end
endmodule : rsr_host_sink
`default_nettype wire
